/* File: common/amp_cfg.svh */
`ifndef AMP_CFG_SVH
`define AMP_CFG_SVH

// clock and derived timing
`define AMP_CLK_MHZ 125
`define AMP_CLK_NS 8
`define AMP_TICK_US 100
`define AMP_CARRIER_HALF_NS 1302

// register offsets
`define AMP_OFS_SYSCTL2 8'h05
`define AMP_OFS_SOFT 8'h1a
`define AMP_OFS_TRIM 8'h1b
`define AMP_OFS_FAULT 8'h1c
`define AMP_OFS_INMUX 8'h20
`define AMP_OFS_OUTMUX 8'h25

// reset values
`define AMP_RST_SHUTDOWN 1'b1
`define AMP_RST_SOFT 5'h0f
`define AMP_RST_FACTORY_SEL 1'b1
`define AMP_RST_FAULT 4'h2
`define AMP_RST_INMUX 32'h0001_7772
`define AMP_RST_OUTMUX 32'h0102_1300

// field positions
`define AMP_SHUT_BIT 6
`define AMP_SOFT_W 5
`define AMP_TRIM_DONE_BIT 6
`define AMP_TRIM_RSVD_BIT 7
`define AMP_TRIM_SEL_BIT 1
`define AMP_CH1_MOD_BIT 23
`define AMP_CH2_MOD_BIT 19
`define AMP_CH1_SRC_LSB 20
`define AMP_CH2_SRC_LSB 16
`define AMP_PIN_A_LSB 20
`define AMP_PIN_STEP 4

// codes
`define AMP_SRC_LEFT 3'b000
`define AMP_SRC_RIGHT 3'b001
`define AMP_SRC_ZERO 3'b110
`define AMP_SS_MIN_CODE 5'd8
`define AMP_FAULT_MIN_CODE 4'd2
`define AMP_FAULT_MAX_CODE 4'd9

// periods in 100 us ticks, soft codes 31 down to 8
`define AMP_SS_TABLE {18'd131964, 18'd98973, 18'd73837, 18'd56556, 18'd42417, \
    18'd32991, 18'd25136, 18'd17281, 18'd12566, 18'd9425, 18'd7031, 18'd5386, \
    18'd4039, 18'd3142, 18'd2394, 18'd1646, 18'd1257, 18'd942, 18'd703, \
    18'd539, 18'd404, 18'd314, 18'd239, 18'd165}
// fault restart codes 9 down to 2, then the ceiling
`define AMP_FAULT_TABLE {18'd13460, 18'd11970, 18'd10470, 18'd8980, 18'd7480, \
    18'd5980, 18'd4490, 18'd2990}
`define AMP_FAULT_CEIL 18'd14960

`endif

/* File: common/amp_pkg.sv */
package amp_pkg;
    typedef enum logic [4:0] {
        AMP_SHUT = 5'b00001,
        AMP_RAMP_UP = 5'b00010,
        AMP_PLAY = 5'b00100,
        AMP_RAMP_DOWN = 5'b01000,
        AMP_FAULT = 5'b10000
    } amp_state_t;
    typedef struct packed {
        logic ch1;
        logic ch2;
    } amp_pwm_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } amp_reg_req_t;
    typedef struct packed {
        logic valid;
        logic [31:0] data;
    } amp_reg_rsp_t;
endpackage

/* File: core/amp_period_timer.sv */
`timescale 1ns/1ps
`include "amp_cfg.svh"
module amp_period_timer import amp_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // control
    input wire logic tick_en,
    input wire logic load,
    input wire logic [17:0] load_val,
    // status
    output logic expired
);
    logic [17:0] count;

    assign expired = (count == 18'h0);

    // load wins over counting so a restart is never swallowed
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count <= 18'h0;
        end else if (load) begin
            count <= load_val;
        end else if (tick_en && !expired) begin
            count <= count - 18'h1;
        end
    end
endmodule

/* File: core/amp_out_router.sv */
`timescale 1ns/1ps
`include "amp_cfg.svh"
module amp_out_router import amp_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // channels and routing
    input wire amp_pwm_t pwm,
    input wire logic drive_en,
    input wire logic [31:0] route,
    // pins a to d
    output logic [3:0] pins
);
    // candidates: channel 1, channel 2, then their complements
    wire [3:0] cand = {~pwm.ch2, ~pwm.ch1, pwm.ch2, pwm.ch1};

    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_pin
            logic q;
            wire [1:0] sel = route[`AMP_PIN_A_LSB - `AMP_PIN_STEP * i +: 2];
            // muted pins sit low, not at half duty
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    q <= 1'b0;
                end else begin
                    q <= drive_en & cand[sel];
                end
            end
            assign pins[i] = q;
        end
    endgenerate
endmodule

/* File: core/amp_seq_regs.sv */
`timescale 1ns/1ps
`include "amp_cfg.svh"
module amp_seq_regs import amp_pkg::*; #(
    parameter int unsigned TICK_CYCLES = `AMP_TICK_US * `AMP_CLK_MHZ
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register port from the serial control port
    input wire amp_reg_req_t reg_req,
    output amp_reg_rsp_t reg_rsp,
    // serial audio slots
    input wire logic [23:0] serial_in_left_slot,
    input wire logic [23:0] serial_in_right_slot,
    input wire logic sample_valid,
    output logic [23:0] ch1_sample,
    output logic [23:0] ch2_sample,
    output logic ch_sample_valid,
    output logic ch1_three_level,
    output logic ch2_three_level,
    // modulator and output pins
    input wire amp_pwm_t pwm_in,
    output logic [3:0] pwm_pins,
    // power stage and pins
    input wire logic power_down_pin_n,
    input wire logic power_stage_fault,
    output logic power_stage_reset,
    output logic soft_period_active,
    output logic shutdown_active,
    // oscillator trim
    input wire logic osc_trim_done,
    output logic osc_trim_start,
    output logic osc_factory_trim
);
    ////////////////////////////////////////////////////////////////////////
    // constants
    localparam logic [23:0][17:0] SS_TAB = `AMP_SS_TABLE;
    localparam logic [7:0][17:0] FAULT_TAB = `AMP_FAULT_TABLE;
    localparam int unsigned CAR_HALF = `AMP_CARRIER_HALF_NS / `AMP_CLK_NS;

    ////////////////////////////////////////////////////////////////////////
    // declarations
    logic shutdown;
    logic [`AMP_SOFT_W-1:0] soft_code;
    logic factory_sel;
    logic trim_done;
    logic [3:0] fault_code;
    logic fault_locked;
    logic [31:0] inmux;
    logic [31:0] outmux;
    logic [31:0] next_inmux;
    logic [31:0] next_outmux;
    logic pdn_meta;
    logic pdn_sync;
    logic [15:0] tick_cnt;
    logic tick_en;
    logic [7:0] car_cnt;
    logic half_wave;
    amp_state_t state;
    amp_state_t next_state;
    logic timer_load;
    logic [17:0] timer_val;
    logic timer_expired;
    amp_pwm_t route_pwm;
    logic route_en;

    ////////////////////////////////////////////////////////////////////////
    // address decode
    wire wr_sys = reg_req.wr && (reg_req.addr == `AMP_OFS_SYSCTL2);
    wire wr_soft = reg_req.wr && (reg_req.addr == `AMP_OFS_SOFT);
    wire wr_trim = reg_req.wr && (reg_req.addr == `AMP_OFS_TRIM);
    wire wr_fault = reg_req.wr && (reg_req.addr == `AMP_OFS_FAULT);
    wire wr_inmux = reg_req.wr && (reg_req.addr == `AMP_OFS_INMUX);
    wire wr_outmux = reg_req.wr && (reg_req.addr == `AMP_OFS_OUTMUX);

    // fault code must be non-reserved: upper nibble zero, code 2 or more
    wire fault_wr_ok = (reg_req.wdata[7:4] == 4'h0)
        && (reg_req.wdata[3:0] >= `AMP_FAULT_MIN_CODE);

    // readback words, reserved bits read at their fixed values
    wire [31:0] rd_sys = 32'(shutdown) << `AMP_SHUT_BIT;
    wire [31:0] rd_trim = (32'h1 << `AMP_TRIM_RSVD_BIT)
        | (32'(trim_done) << `AMP_TRIM_DONE_BIT)
        | (32'(factory_sel) << `AMP_TRIM_SEL_BIT);
    wire [31:0] rd_data =
        (reg_req.addr == `AMP_OFS_SYSCTL2) ? rd_sys :
        (reg_req.addr == `AMP_OFS_SOFT) ? 32'(soft_code) :
        (reg_req.addr == `AMP_OFS_TRIM) ? rd_trim :
        (reg_req.addr == `AMP_OFS_FAULT) ? 32'(fault_code) :
        (reg_req.addr == `AMP_OFS_INMUX) ? inmux :
        (reg_req.addr == `AMP_OFS_OUTMUX) ? outmux : 32'h0;

    ////////////////////////////////////////////////////////////////////////
    // register writes

    function automatic logic src_ok(input logic [2:0] code);
        src_ok = (code == `AMP_SRC_LEFT) || (code == `AMP_SRC_RIGHT)
            || (code == `AMP_SRC_ZERO);
    endfunction

    // reserved source codes leave the old routing in place
    always_comb begin
        next_inmux = inmux;
        next_inmux[`AMP_CH1_MOD_BIT] = reg_req.wdata[`AMP_CH1_MOD_BIT];
        next_inmux[`AMP_CH2_MOD_BIT] = reg_req.wdata[`AMP_CH2_MOD_BIT];
        if (src_ok(reg_req.wdata[`AMP_CH1_SRC_LSB +: 3])) begin
            next_inmux[`AMP_CH1_SRC_LSB +: 3] =
                reg_req.wdata[`AMP_CH1_SRC_LSB +: 3];
        end
        if (src_ok(reg_req.wdata[`AMP_CH2_SRC_LSB +: 3])) begin
            next_inmux[`AMP_CH2_SRC_LSB +: 3] =
                reg_req.wdata[`AMP_CH2_SRC_LSB +: 3];
        end
    end

    // only the four pin fields are writable, the rest stays fixed
    always_comb begin
        next_outmux = outmux;
        for (int i = 0; i < 4; i++) begin
            next_outmux[`AMP_PIN_A_LSB - `AMP_PIN_STEP * i +: 2] =
                reg_req.wdata[`AMP_PIN_A_LSB - `AMP_PIN_STEP * i +: 2];
        end
    end

    // control registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            shutdown <= `AMP_RST_SHUTDOWN;
            soft_code <= `AMP_RST_SOFT;
            inmux <= `AMP_RST_INMUX;
            outmux <= `AMP_RST_OUTMUX;
        end else begin
            if (wr_sys) begin
                shutdown <= reg_req.wdata[`AMP_SHUT_BIT];
            end
            if (wr_soft) begin
                soft_code <= reg_req.wdata[`AMP_SOFT_W-1:0];
            end
            if (wr_inmux) begin
                inmux <= next_inmux;
            end
            if (wr_outmux) begin
                outmux <= next_outmux;
            end
        end
    end

    // fault period takes one good write per reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fault_code <= `AMP_RST_FAULT;
            fault_locked <= 1'b0;
        end else if (wr_fault && fault_wr_ok && !fault_locked) begin
            fault_code <= reg_req.wdata[3:0];
            fault_locked <= 1'b1;
        end
    end

    // trim control: a write starts trimming, done is set by the oscillator
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            factory_sel <= `AMP_RST_FACTORY_SEL;
            trim_done <= 1'b0;
            osc_trim_start <= 1'b0;
            osc_factory_trim <= 1'b0;
        end else begin
            osc_trim_start <= wr_trim;
            if (wr_trim) begin
                factory_sel <= reg_req.wdata[`AMP_TRIM_SEL_BIT];
                osc_factory_trim <= ~reg_req.wdata[`AMP_TRIM_SEL_BIT];
            end
            // a done that lands with a new start is kept
            if (osc_trim_done) begin
                trim_done <= 1'b1;
            end else if (wr_trim) begin
                trim_done <= 1'b0;
            end
        end
    end

    // readback, answered one cycle after the request
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rsp <= '0;
        end else begin
            reg_rsp.valid <= reg_req.rd;
            reg_rsp.data <= reg_req.rd ? rd_data : 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // input routing and modulation mode

    wire [2:0] ch1_src = inmux[`AMP_CH1_SRC_LSB +: 3];
    wire [2:0] ch2_src = inmux[`AMP_CH2_SRC_LSB +: 3];
    wire [23:0] ch1_pick = (ch1_src == `AMP_SRC_LEFT) ? serial_in_left_slot :
        (ch1_src == `AMP_SRC_RIGHT) ? serial_in_right_slot : 24'h0;
    wire [23:0] ch2_pick = (ch2_src == `AMP_SRC_LEFT) ? serial_in_left_slot :
        (ch2_src == `AMP_SRC_RIGHT) ? serial_in_right_slot : 24'h0;

    // samples held between strobes so the modulator sees stable words
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ch1_sample <= 24'h0;
            ch2_sample <= 24'h0;
            ch_sample_valid <= 1'b0;
            ch1_three_level <= 1'b0;
            ch2_three_level <= 1'b0;
        end else begin
            ch_sample_valid <= sample_valid;
            if (sample_valid) begin
                ch1_sample <= ch1_pick;
                ch2_sample <= ch2_pick;
            end
            ch1_three_level <= inmux[`AMP_CH1_MOD_BIT];
            ch2_three_level <= inmux[`AMP_CH2_MOD_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin sync, tick divider and half-duty carrier

    // pin is asynchronous to clk
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pdn_meta <= 1'b0;
            pdn_sync <= 1'b0;
        end else begin
            pdn_meta <= power_down_pin_n;
            pdn_sync <= pdn_meta;
        end
    end

    // 100 us enable; coarse but periods are only approximate anyway
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tick_cnt <= 16'h0;
            tick_en <= 1'b0;
        end else if (tick_cnt == 16'(TICK_CYCLES - 1)) begin
            tick_cnt <= 16'h0;
            tick_en <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 16'h1;
            tick_en <= 1'b0;
        end
    end

    // square wave used while soft starting or stopping
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            car_cnt <= 8'h0;
            half_wave <= 1'b0;
        end else if (car_cnt == 8'(CAR_HALF - 1)) begin
            car_cnt <= 8'h0;
            half_wave <= ~half_wave;
        end else begin
            car_cnt <= car_cnt + 8'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer

    wire run = !shutdown && pdn_sync;
    wire ss_skip = (soft_code[4:3] == 2'b00);
    wire [4:0] ss_idx = ss_skip ? 5'h0 : 5'(soft_code - `AMP_SS_MIN_CODE);
    wire [17:0] ss_val = SS_TAB[ss_idx];
    wire [3:0] ft_idx = 4'(fault_code - `AMP_FAULT_MIN_CODE);
    wire [17:0] ft_val = (fault_code > `AMP_FAULT_MAX_CODE) ? `AMP_FAULT_CEIL :
        FAULT_TAB[ft_idx[2:0]];

    // fault has priority; a ramp is always finished or reversed by a ramp
    always_comb begin
        next_state = state;
        timer_load = 1'b0;
        timer_val = ss_val;
        if (power_stage_fault && state != AMP_FAULT) begin
            next_state = AMP_FAULT;
            timer_load = 1'b1;
            timer_val = ft_val;
        end else begin
            case (state)
                AMP_SHUT: begin
                    if (run && ss_skip) begin
                        next_state = AMP_PLAY;
                    end else if (run) begin
                        next_state = AMP_RAMP_UP;
                        timer_load = 1'b1;
                    end
                end
                AMP_RAMP_UP: begin
                    if (!run) begin
                        next_state = AMP_RAMP_DOWN;
                        timer_load = 1'b1;
                    end else if (timer_expired) begin
                        next_state = AMP_PLAY;
                    end
                end
                AMP_PLAY: begin
                    if (!run && ss_skip) begin
                        next_state = AMP_SHUT;
                    end else if (!run) begin
                        next_state = AMP_RAMP_DOWN;
                        timer_load = 1'b1;
                    end
                end
                AMP_RAMP_DOWN: begin
                    if (timer_expired) begin
                        next_state = AMP_SHUT;
                    end
                end
                AMP_FAULT: begin
                    if (timer_expired) begin
                        next_state = AMP_SHUT;
                    end
                end
                default: begin
                    next_state = AMP_SHUT;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= AMP_SHUT;
        end else begin
            state <= next_state;
        end
    end

    // status outputs follow the state one cycle later, like the pins
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            power_stage_reset <= 1'b0;
            soft_period_active <= 1'b0;
            shutdown_active <= 1'b1;
        end else begin
            power_stage_reset <= (state == AMP_FAULT);
            soft_period_active <= (state == AMP_RAMP_UP)
                || (state == AMP_RAMP_DOWN);
            shutdown_active <= (state == AMP_SHUT) || (state == AMP_FAULT);
        end
    end

    // pins: audio in play, half duty in ramps, low otherwise
    always_comb begin
        route_pwm = pwm_in;
        route_en = 1'b0;
        if (state == AMP_PLAY) begin
            route_en = 1'b1;
        end else if (state == AMP_RAMP_UP || state == AMP_RAMP_DOWN) begin
            route_pwm = '{ch1: half_wave, ch2: half_wave};
            route_en = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // submodules

    amp_period_timer u_timer (
        .clk(clk),
        .reset_n(reset_n),
        .tick_en(tick_en),
        .load(timer_load),
        .load_val(timer_val),
        .expired(timer_expired)
    );

    amp_out_router u_router (
        .clk(clk),
        .reset_n(reset_n),
        .pwm(route_pwm),
        .drive_en(route_en),
        .route(outmux),
        .pins(pwm_pins)
    );
endmodule

/* File: tb/amp_seq_regs_monitor.sv */
`timescale 1ns/1ps
module amp_seq_regs_monitor import amp_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register port
    input wire amp_reg_req_t reg_req,
    input wire amp_reg_rsp_t reg_rsp,
    // audio and power stage
    input wire logic sample_valid,
    input wire logic ch_sample_valid,
    input wire logic power_stage_fault,
    input wire logic power_stage_reset,
    input wire logic shutdown_active,
    input wire logic [3:0] pwm_pins,
    // trim
    input wire logic osc_trim_start,
    input wire logic osc_factory_trim
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // trim register write seen at the port
    wire trim_wr = reg_req.wr && reg_req.addr == 8'h1b;

    chk_read_answer: assert property (reg_req.rd |=> reg_rsp.valid)
        else $error("read got no answer");
    chk_no_stray: assert property (!reg_req.rd |=> !reg_rsp.valid)
        else $error("answer without read");
    chk_idle_zero: assert property (!reg_rsp.valid |-> reg_rsp.data == 32'h0)
        else $error("data not zero while idle");
    chk_trim_start: assert property (trim_wr |=> osc_trim_start)
        else $error("trim write did not start trim");
    chk_factory_sel: assert property (trim_wr |=> osc_factory_trim == !$past(reg_req.wdata[1]))
        else $error("factory trim select wrong");
    chk_sample_strobe: assert property (sample_valid |=> ch_sample_valid)
        else $error("sample strobe lost");
    chk_fault_cause: assert property ($rose(power_stage_reset) |-> $past(power_stage_fault, 2))
        else $error("stage reset without fault");
    chk_stage_mute: assert property (power_stage_reset |-> pwm_pins == 4'h0)
        else $error("pins active in fault wait");
    chk_shut_mute: assert property (shutdown_active && $past(shutdown_active) |-> pwm_pins == 4'h0)
        else $error("pins active in shutdown");
endmodule

bind amp_seq_regs amp_seq_regs_monitor u_mon (.clk(clk), .reset_n(reset_n), .reg_req(reg_req),
    .reg_rsp(reg_rsp), .sample_valid(sample_valid), .ch_sample_valid(ch_sample_valid),
    .power_stage_fault(power_stage_fault), .power_stage_reset(power_stage_reset),
    .shutdown_active(shutdown_active), .pwm_pins(pwm_pins), .osc_trim_start(osc_trim_start),
    .osc_factory_trim(osc_factory_trim));

/* File: tb/amp_host_model.sv */
`timescale 1ns/1ps
module amp_host_model import amp_pkg::*; (
    // clock
    input wire logic clk,
    // register port
    output amp_reg_req_t reg_req,
    input wire amp_reg_rsp_t reg_rsp
);
    initial reg_req = '0;
    ////////////////////////////////////////////////////////////////////////////////
    // one word per access, changed only at the falling edge
    task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
        @(negedge clk);
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk);
        reg_req = '0;
    endtask
    // answer stands one cycle, so it is caught at each falling edge
    task automatic read_reg(input logic [7:0] a, output logic [31:0] d);
        bit got;
        got = 0;
        d = 'x;
        @(negedge clk);
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        for (int n = 0; n < 3 && !got; n++) begin
            @(negedge clk);
            reg_req = '0;
            if (reg_rsp.valid === 1'b1) begin
                d = reg_rsp.data;
                got = 1;
            end
        end
    endtask
endmodule

/* File: tb/amp_sequencing_routing_regs_tb.sv */
`timescale 1ns/1ps
module amp_sequencing_routing_regs_tb import amp_pkg::*;;
    localparam int TICK = 4;
    logic clk, reset_n, sample_valid, power_down_pin_n, power_stage_fault, osc_trim_done;
    logic [23:0] left_word, right_word, ch1_sample, ch2_sample;
    logic ch_sample_valid, ch1_three_level, ch2_three_level, power_stage_reset;
    logic soft_period_active, shutdown_active, osc_trim_start, osc_factory_trim;
    logic [3:0] pwm_pins;
    amp_reg_req_t reg_req;
    amp_reg_rsp_t reg_rsp;
    amp_pwm_t pwm_in;
    int n_mismatch, checked, len;
    logic [31:0] rd_val, route;
    logic [2:0] c1, c2, e1, e2;
    logic m1, m2;
    logic [7:0] ra [7] = '{8'h05, 8'h1a, 8'h1b, 8'h1c, 8'h20, 8'h25, 8'h30};
    logic [31:0] rv [7] = '{32'h40, 32'h0f, 32'h82, 32'h02, 32'h17772, 32'h1021300, 32'h0};
    logic [2:0] cs1 [5] = '{3'd1, 3'd6, 3'd3, 3'd0, 3'd7};
    logic [2:0] cs2 [5] = '{3'd0, 3'd5, 3'd6, 3'd1, 3'd2};

    always #4 clk = ~clk;

    amp_seq_regs #(.TICK_CYCLES(TICK)) u_dut (.clk(clk), .reset_n(reset_n), .reg_req(reg_req),
        .reg_rsp(reg_rsp), .serial_in_left_slot(left_word), .serial_in_right_slot(right_word),
        .sample_valid(sample_valid), .ch1_sample(ch1_sample), .ch2_sample(ch2_sample),
        .ch_sample_valid(ch_sample_valid), .ch1_three_level(ch1_three_level),
        .ch2_three_level(ch2_three_level), .pwm_in(pwm_in), .pwm_pins(pwm_pins),
        .power_down_pin_n(power_down_pin_n), .power_stage_fault(power_stage_fault),
        .power_stage_reset(power_stage_reset), .soft_period_active(soft_period_active),
        .shutdown_active(shutdown_active), .osc_trim_done(osc_trim_done),
        .osc_trim_start(osc_trim_start), .osc_factory_trim(osc_factory_trim));
    amp_host_model u_host (.clk(clk), .reg_req(reg_req), .reg_rsp(reg_rsp));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp);
        u_host.read_reg(a, rd_val);
        compare(rd_val, exp);
    endtask
    function automatic logic [23:0] src_word(input logic [2:0] c, input logic [23:0] l, r);
        return c == 3'd0 ? l : (c == 3'd1 ? r : 24'h0);
    endfunction
    function automatic bit src_ok(input logic [2:0] c);
        return c == 3'd0 || c == 3'd1 || c == 3'd6;
    endfunction
    // pin a takes bits 21:20, each next pin four bits lower
    function automatic logic [3:0] pin_word(input logic [31:0] r, input amp_pwm_t p);
        logic [3:0] v;
        for (int i = 0; i < 4; i++) begin
            v[i] = r[20-4*i] ? p.ch2 : p.ch1;
            v[i] = v[i] ^ r[21-4*i];
        end
        return v;
    endfunction
    // first tick lands one to four cycles after the load, status adds one edge each way
    function automatic bit in_span(input int n, input int base);
        return n >= base - TICK + 2 && n <= base + 1;
    endfunction
    // length of a high level, 0 = ramp, 1 = fault wait
    task automatic span(input bit sel, output int n);
        n = 0;
        for (int w = 0; w < 40 && !(sel ? power_stage_reset : soft_period_active); w++)
            @(negedge clk);
        while ((sel ? power_stage_reset : soft_period_active) === 1'b1 && n < 70000) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 0;
        reset_n = 0;
        {sample_valid, power_stage_fault, osc_trim_done} = '0;
        power_down_pin_n = 1;
        {left_word, right_word} = '0;
        pwm_in = '0;
        void'($urandom(32'h9f12));
        repeat (2) @(negedge clk);
        reset_n = 1;
        for (int i = 0; i < 7; i++) expect_reg(ra[i], rv[i]);
        $display("test reset values done");
        u_host.write_reg(8'h1b, 32'h0);
        compare(osc_factory_trim, 1);
        expect_reg(8'h1b, 32'h80);
        @(negedge clk) osc_trim_done = 1;
        @(negedge clk) osc_trim_done = 0;
        expect_reg(8'h1b, 32'hc0);
        u_host.write_reg(8'h1b, 32'hc2);
        expect_reg(8'h1b, 32'h82);
        compare(osc_factory_trim, 0);
        $display("test trim done");
        u_host.write_reg(8'h1c, 32'h01);
        expect_reg(8'h1c, 32'h02);
        u_host.write_reg(8'h1c, 32'h03);
        expect_reg(8'h1c, 32'h03);
        u_host.write_reg(8'h1c, 32'h09);
        expect_reg(8'h1c, 32'h03);
        $display("test fault period register done");
        {e1, e2} = {3'd0, 3'd1};
        for (int i = 0; i < 5; i++) begin
            {m1, m2} = 2'($urandom);
            {c1, c2} = {cs1[i], cs2[i]};
            u_host.write_reg(8'h20, {8'h00, m1, c1, m2, c2, 16'h7772});
            if (src_ok(c1)) e1 = c1;
            if (src_ok(c2)) e2 = c2;
            expect_reg(8'h20, {8'h00, m1, e1, m2, e2, 16'h7772});
            @(negedge clk);
            {left_word, right_word} = {24'($urandom), 24'($urandom)};
            sample_valid = 1;
            @(negedge clk) sample_valid = 0;
            compare(ch_sample_valid, 1);
            compare(ch1_sample, src_word(e1, left_word, right_word));
            compare(ch2_sample, src_word(e2, left_word, right_word));
            compare({ch1_three_level, ch2_three_level}, {m1, m2});
        end
        $display("test input routing done");
        u_host.write_reg(8'h20, 32'h17772);
        u_host.write_reg(8'h1a, 32'h00);
        u_host.write_reg(8'h05, 32'h00);
        repeat (8) @(negedge clk);
        compare({soft_period_active, shutdown_active}, 0);
        for (int i = 0; i < 8; i++) begin
            route = 32'h0100_0000;
            for (int k = 0; k < 4; k++) route[20-4*k +: 2] = i < 4 ? 2'(i) : 2'($urandom);
            u_host.write_reg(8'h25, route);
            @(negedge clk) pwm_in = amp_pwm_t'(2'($urandom));
            repeat (2) @(negedge clk);
            compare(pwm_pins, pin_word(route, pwm_in));
        end
        $display("test output routing done");
        u_host.write_reg(8'h1a, 32'h08);
        @(negedge clk) power_down_pin_n = 0;
        span(0, len);
        compare(in_span(len, 165 * TICK), 1);
        repeat (4) @(negedge clk);
        compare({shutdown_active, pwm_pins}, 5'h10);
        power_down_pin_n = 1;
        span(0, len);
        compare(in_span(len, 165 * TICK), 1);
        repeat (4) @(negedge clk);
        compare(shutdown_active, 0);
        $display("test soft ramps done");
        @(negedge clk) power_stage_fault = 1;
        @(negedge clk) power_stage_fault = 0;
        span(1, len);
        compare(in_span(len, 4490 * TICK), 1);
        repeat (20) @(negedge clk);
        compare(shutdown_active, 0);
        // a fresh reset must reopen the one-shot fault period write
        reset_n = 0;
        @(negedge clk) reset_n = 1;
        u_host.write_reg(8'h1c, 32'h0c);
        expect_reg(8'h1c, 32'h0c);
        $display("test fault restart done");
        report_and_stop;
    end

    // cut a hang short well past the expected run length
    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        $display("watchdog expired");
        report_and_stop;
    end
endmodule
